// >>> rtl/pefr_pkg.sv
package pefr_pkg;
  // ==========================================================
  // Widths and types
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int MEAS_W     = 12;
  localparam int CHG_STAT_W = 2;
  localparam int NUM_COMP   = 3;

  typedef logic [ADDR_W-1:0]     pefr_addr_t;
  typedef logic [DATA_W-1:0]     pefr_data_t;
  typedef logic [MEAS_W-1:0]     pefr_meas_t;
  typedef logic [CHG_STAT_W-1:0] pefr_chg_t;

  // ==========================================================
  // Register map
  localparam pefr_addr_t FLAGS_ONE_ADDR = 8'h05;
  localparam pefr_addr_t FLAGS_TWO_ADDR = 8'h06;
  localparam pefr_data_t FLAGS_RESET    = 8'h00;
  localparam pefr_data_t UNMAPPED_DATA  = 8'h00;

  // ==========================================================
  // Field positions, first flag register
  localparam int F1_THERMAL_REG  = 7;
  localparam int F1_SAFETY_TMO   = 6;
  localparam int F1_WAKE_A       = 5;
  localparam int F1_WAKE_B       = 4;
  localparam int F1_ADC_DONE     = 3;
  localparam int F1_THRESHOLD_A  = 2;
  localparam int F1_THRESHOLD_B  = 1;
  localparam int F1_THRESHOLD_C  = 0;

  // ==========================================================
  // Field positions, second flag register
  localparam int F2_CHARGE_STATE = 7;
  localparam int F2_SEQ_GOOD     = 6;
  localparam int F2_STEPDOWN_NG  = 5;
  localparam int F2_UPDOWN_NG    = 4;
  localparam int F2_REG_A_NG     = 3;
  localparam int F2_REG_B_NG     = 2;
  localparam int F2_INPUT_GOOD   = 1;
  localparam int F2_INPUT_OVP    = 0;
endpackage : pefr_pkg

// >>> rtl/pefr_flag_if.sv
`timescale 1ns/10ps
interface pefr_flag_if;
  import pefr_pkg::*;
  pefr_data_t setVec;   // Event strobes, one per bit
  logic       clearRd;  // Clearing read of this register
  pefr_data_t flags;    // Sticky flag state

  modport owner (input setVec, input clearRd, output flags);
  modport user  (output setVec, output clearRd, input flags);
endinterface : pefr_flag_if

// >>> rtl/pefr_flag_reg.sv
`timescale 1ns/10ps
module pefr_flag_reg (
  input wire logic   clk,
  input wire logic   rst,
  pefr_flag_if.owner flagPort
);
  import pefr_pkg::*;

  pefr_data_t flags;
  pefr_data_t next_flags;

  // Set wins over the clearing read so no event falls in the gap
  always_comb begin
    next_flags = flags;
    if (flagPort.clearRd) begin
      next_flags = FLAGS_RESET;
    end
    next_flags = next_flags | flagPort.setVec;
  end

  // Flags return to zero at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign flagPort.flags = flags;
endmodule : pefr_flag_reg

// >>> rtl/pefr_change_det.sv
`timescale 1ns/10ps
module pefr_change_det #(
  parameter int W = 1
) (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [W-1:0] value,
  output logic             changed,
  output logic             fell
);
  logic [W-1:0] prevValue;
  logic [W-1:0] next_prevValue;
  logic         primed;
  logic         next_primed;

  // First cycle after reset only learns the value; the level a rail
  // settles at during reset is no change and must not raise a flag
  always_comb begin
    next_prevValue = value;
    next_primed    = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevValue <= '0;
      primed    <= 1'b0;
    end else begin
      prevValue <= next_prevValue;
      primed    <= next_primed;
    end
  end

  // Fell is only meaningful for single-bit levels (bit 0 watched)
  assign changed = primed && (value != prevValue);
  assign fell    = primed && prevValue[0] && !value[0];
endmodule : pefr_change_det

// >>> rtl/pefr_event_flags.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Register at 0x05, eight bits, resets zero, read-only, read clears it.
// - Register at 0x06, eight bits, resets zero, read-only, read clears it.
// - Bit 7 of 0x05 sets on thermal regulation, holds until read.
// - Bit 6 of 0x05 sets when the safety timer expires; read clears.
// - Bit 5 of 0x05 sets when wake timer A condition is met.
// - Bit 4 of 0x05 sets when wake timer B condition is met.
// - Bit 3 of 0x05 sets on conversion done, one-shot mode only.
// - Bits 2..0 of 0x05 set on threshold crossing in chosen direction.
// - Bit 7 of 0x06 sets whenever the charge status field changes.
// - Bit 6 of 0x06 sets on any sequence power-good change.
// - Bit 5 of 0x06 sets on a step-down power-not-good event.
// - Bit 4 of 0x06 sets on a buck-boost power-not-good event.
// - Bit 3 of 0x06 sets on a regulator A power-not-good event.
// - Bit 2 of 0x06 sets on a regulator B power-not-good event.
// - Bit 1 of 0x06 sets on any input power-good change.
// - Bit 0 of 0x06 sets on input overvoltage fault.
module pefr_event_flags (
  input  wire logic                clk,
  input  wire logic                rst,
  // Register read port from the serial control bus front end
  input  wire logic                regRead,
  input  wire pefr_pkg::pefr_addr_t regAddr,
  output logic                     regRvalid,
  output pefr_pkg::pefr_data_t     regRdata,
  // Flag state for the interrupt logic elsewhere in the device
  output pefr_pkg::pefr_data_t     eventFlagsOne,
  output pefr_pkg::pefr_data_t     eventFlagsTwo,
  // Charger and timer events
  input  wire logic                thermalRegulationActive,
  input  wire logic                safetyTimerExpired,
  input  wire logic                wakeTimerAMet,
  input  wire logic                wakeTimerBMet,
  // Converter completion and mode
  input  wire logic                adcDone,
  input  wire logic                adcOneShotMode,
  // Threshold comparators: fresh sample strobe, samples, limits, sense
  input  wire logic                measValid,
  input  wire pefr_pkg::pefr_meas_t thresholdAMeas,
  input  wire pefr_pkg::pefr_meas_t thresholdBMeas,
  input  wire pefr_pkg::pefr_meas_t thresholdCMeas,
  input  wire pefr_pkg::pefr_meas_t thresholdALimit,
  input  wire pefr_pkg::pefr_meas_t thresholdBLimit,
  input  wire pefr_pkg::pefr_meas_t thresholdCLimit,
  input  wire logic                thresholdADirection,
  input  wire logic                thresholdBDirection,
  input  wire logic                thresholdCDirection,
  // Status levels of the charger, rails and input
  input  wire pefr_pkg::pefr_chg_t chargeStatus,
  input  wire logic                sequenceGood,
  // Rail and input good levels, 1 = good; input overvoltage, 1 = fault
  input  wire logic                stepdownGood,
  input  wire logic                updownGood,
  input  wire logic                regulatorAGood,
  input  wire logic                regulatorBGood,
  input  wire logic                inputGood,
  input  wire logic                inputOvervoltage
);
  import pefr_pkg::*;

  // ==========================================================
  // Flag registers
  // One carrier per register: event strobes in, sticky state out
  pefr_flag_if flagsOne ();
  pefr_flag_if flagsTwo ();

  // First register, offset 0x05: charger, timer and converter events
  pefr_flag_reg u_flagsOne (
    .clk      (clk),
    .rst      (rst),
    .flagPort (flagsOne.owner)
  );

  // Second register, offset 0x06: charge state, rails and input
  pefr_flag_reg u_flagsTwo (
    .clk      (clk),
    .rst      (rst),
    .flagPort (flagsTwo.owner)
  );

  // Flag state leaves straight from the flag flops, with no extra
  // stage, so the interrupt logic sees the same value a read returns
  assign eventFlagsOne = flagsOne.flags;
  assign eventFlagsTwo = flagsTwo.flags;

  // ==========================================================
  // Threshold comparators
  // Per-comparator sample, limit and sense, indexed A to C
  pefr_meas_t              compMeas  [NUM_COMP];
  pefr_meas_t              compLimit [NUM_COMP];
  logic [NUM_COMP-1:0]     compAbove;
  logic [NUM_COMP-1:0]     compMet;

  // Edge tracking: last met state and the crossing strobe
  logic [NUM_COMP-1:0]     compPrevMet;
  logic [NUM_COMP-1:0]     next_compPrevMet;
  logic [NUM_COMP-1:0]     compCross;

  // Index 0 is comparator A, which lands on the highest flag bit
  assign compMeas[0]  = thresholdAMeas;
  assign compMeas[1]  = thresholdBMeas;
  assign compMeas[2]  = thresholdCMeas;

  // Limits come from the threshold settings elsewhere in the device
  assign compLimit[0] = thresholdALimit;
  assign compLimit[1] = thresholdBLimit;
  assign compLimit[2] = thresholdCLimit;

  // Direction bits: 1 = above the limit, 0 = below it
  assign compAbove    = {thresholdCDirection, thresholdBDirection,
                         thresholdADirection};

  // Direction bit picks above or below; only the edge into the met
  // condition counts, so a sample that stays past the limit does not
  // refill the flag after every read
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COMP; gi++) begin : g_comp
      assign compMet[gi] = compAbove[gi] ?
                           (compMeas[gi] > compLimit[gi]) :
                           (compMeas[gi] < compLimit[gi]);
      assign compCross[gi] = measValid && compMet[gi] &&
                             !compPrevMet[gi];
    end
  endgenerate

  // Last met state is only advanced on a fresh sample
  always_comb begin
    next_compPrevMet = compPrevMet;
    if (measValid) begin
      next_compPrevMet = compMet;
    end
  end

  // Reset state counts as not met, so a first sample already past
  // the limit raises the flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compPrevMet <= '0;
    end else begin
      compPrevMet <= next_compPrevMet;
    end
  end

  // ==========================================================
  // Status change detection
  // Either-direction changes of status levels
  logic chargeChanged;
  logic seqChanged;
  logic inputChanged;

  // Falls of the rail good levels
  logic stepdownFell;
  logic updownFell;
  logic regAFell;
  logic regBFell;

  // Charge state is a two-bit field; any step between codes counts
  pefr_change_det #(.W(CHG_STAT_W)) u_chargeDet (
    .clk     (clk),
    .rst     (rst),
    .value   (chargeStatus),
    .changed (chargeChanged),
    .fell    ()
  );

  // Sequence good: a change in either direction counts
  pefr_change_det #(.W(1)) u_seqDet (
    .clk     (clk),
    .rst     (rst),
    .value   (sequenceGood),
    .changed (seqChanged),
    .fell    ()
  );

  // Input good: a change in either direction counts
  pefr_change_det #(.W(1)) u_inputDet (
    .clk     (clk),
    .rst     (rst),
    .value   (inputGood),
    .changed (inputChanged),
    .fell    ()
  );

  // A not-good event is the good level dropping away; the climb
  // back to good raises nothing
  pefr_change_det #(.W(1)) u_stepdownDet (
    .clk     (clk),
    .rst     (rst),
    .value   (stepdownGood),
    .changed (),
    .fell    (stepdownFell)
  );

  // Up-down converter rail
  pefr_change_det #(.W(1)) u_updownDet (
    .clk     (clk),
    .rst     (rst),
    .value   (updownGood),
    .changed (),
    .fell    (updownFell)
  );

  // Regulator A rail
  pefr_change_det #(.W(1)) u_regADet (
    .clk     (clk),
    .rst     (rst),
    .value   (regulatorAGood),
    .changed (),
    .fell    (regAFell)
  );

  // Regulator B rail
  pefr_change_det #(.W(1)) u_regBDet (
    .clk     (clk),
    .rst     (rst),
    .value   (regulatorBGood),
    .changed (),
    .fell    (regBFell)
  );

  // ==========================================================
  // Conversion done gate
  logic adcDoneOneShot;

  // Continuous mode finishes conversions too, but only a one-shot
  // conversion is reported
  assign adcDoneOneShot = adcDone && adcOneShotMode;

  // ==========================================================
  // Event strobes into the flag registers
  // Level sources (thermal regulation, overvoltage) keep refilling
  // while active, so a read during the condition reads back set again
  // First register: charger, timer and converter strobes
  always_comb begin
    flagsOne.setVec = FLAGS_RESET;
    flagsOne.setVec[F1_THERMAL_REG] = thermalRegulationActive;
    flagsOne.setVec[F1_SAFETY_TMO]  = safetyTimerExpired;
    flagsOne.setVec[F1_WAKE_A]      = wakeTimerAMet;
    flagsOne.setVec[F1_WAKE_B]      = wakeTimerBMet;
    flagsOne.setVec[F1_ADC_DONE]    = adcDoneOneShot;
    flagsOne.setVec[F1_THRESHOLD_A] = compCross[0];
    flagsOne.setVec[F1_THRESHOLD_B] = compCross[1];
    flagsOne.setVec[F1_THRESHOLD_C] = compCross[2];
  end

  // Second register: charge state, rail and input strobes
  always_comb begin
    flagsTwo.setVec = FLAGS_RESET;
    flagsTwo.setVec[F2_CHARGE_STATE] = chargeChanged;
    flagsTwo.setVec[F2_SEQ_GOOD]     = seqChanged;
    flagsTwo.setVec[F2_STEPDOWN_NG]  = stepdownFell;
    flagsTwo.setVec[F2_UPDOWN_NG]    = updownFell;
    flagsTwo.setVec[F2_REG_A_NG]     = regAFell;
    flagsTwo.setVec[F2_REG_B_NG]     = regBFell;
    flagsTwo.setVec[F2_INPUT_GOOD]   = inputChanged;
    flagsTwo.setVec[F2_INPUT_OVP]    = inputOvervoltage;
  end

  // ==========================================================
  // Read port
  // Address hits, one compare per register
  logic       hitOne;
  logic       hitTwo;

  // Next answer, registered below
  logic       next_regRvalid;
  pefr_data_t next_regRdata;

  assign hitOne = regRead && (regAddr == FLAGS_ONE_ADDR);
  assign hitTwo = regRead && (regAddr == FLAGS_TWO_ADDR);

  // Clear lands on the same edge that captures the data, so the host
  // sees exactly what it clears
  assign flagsOne.clearRd = hitOne;
  assign flagsTwo.clearRd = hitTwo;

  // Unmapped reads answer zero; no write path exists at all, and an
  // unmapped read clears nothing
  always_comb begin
    next_regRvalid = regRead;
    next_regRdata  = UNMAPPED_DATA;
    if (hitOne) begin
      next_regRdata = flagsOne.flags;
    end else if (hitTwo) begin
      next_regRdata = flagsTwo.flags;
    end
  end

  // Fixed latency: the answer comes one edge after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRvalid <= 1'b0;
      regRdata  <= UNMAPPED_DATA;
    end else begin
      regRvalid <= next_regRvalid;
      regRdata  <= next_regRdata;
    end
  end
endmodule : pefr_event_flags

// >>> verif/pefr_event_flags_asserts.sv
`timescale 1ns/10ps
// ==========
// Flag register checker
module pefr_event_flags_asserts (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 regRead,
  input wire pefr_pkg::pefr_addr_t regAddr,
  input wire logic                 regRvalid,
  input wire pefr_pkg::pefr_data_t regRdata,
  input wire pefr_pkg::pefr_data_t eventFlagsOne,
  input wire pefr_pkg::pefr_data_t eventFlagsTwo,
  input wire logic                 thermalRegulationActive,
  input wire logic                 adcDone,
  input wire logic                 adcOneShotMode,
  input wire logic                 inputOvervoltage
);
  import pefr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Every read gets exactly one answer, one edge later
  chk_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered");
  chk_answer_once: assert property (!regRead |=> !regRvalid)
    else $error("answer without read");
  chk_unmapped_zero: assert property (
    regRead && regAddr != FLAGS_ONE_ADDR && regAddr != FLAGS_TWO_ADDR
    |=> regRdata == 8'h00) else $error("unmapped read not zero");
  // Read data is the flag state just before the clearing edge
  chk_read_one: assert property (
    regRead && regAddr == FLAGS_ONE_ADDR |=> regRdata == $past(eventFlagsOne))
    else $error("first register read data wrong");
  chk_read_two: assert property (
    regRead && regAddr == FLAGS_TWO_ADDR |=> regRdata == $past(eventFlagsTwo))
    else $error("second register read data wrong");
  // Flags only drop through a read of their own register
  chk_sticky_one: assert property (
    !(regRead && regAddr == FLAGS_ONE_ADDR) |=>
    (eventFlagsOne & $past(eventFlagsOne)) == $past(eventFlagsOne))
    else $error("first register flag lost");
  chk_sticky_two: assert property (
    !(regRead && regAddr == FLAGS_TWO_ADDR) |=>
    (eventFlagsTwo & $past(eventFlagsTwo)) == $past(eventFlagsTwo))
    else $error("second register flag lost");
  chk_one_clears: assert property (
    regRead && regAddr == FLAGS_ONE_ADDR |=>
    eventFlagsOne[7] == $past(thermalRegulationActive))
    else $error("thermal flag clear or set wrong");
  chk_ovp_set: assert property (inputOvervoltage |=> eventFlagsTwo[0])
    else $error("overvoltage flag not set");
  chk_adc_set: assert property (
    adcDone && adcOneShotMode |=> eventFlagsOne[3])
    else $error("conversion flag not set");
endmodule : pefr_event_flags_asserts

bind pefr_event_flags pefr_event_flags_asserts u_chk (
  .clk(clk),
  .rst(rst),
  .regRead(regRead),
  .regAddr(regAddr),
  .regRvalid(regRvalid),
  .regRdata(regRdata),
  .eventFlagsOne(eventFlagsOne),
  .eventFlagsTwo(eventFlagsTwo),
  .thermalRegulationActive(thermalRegulationActive),
  .adcDone(adcDone),
  .adcOneShotMode(adcOneShotMode),
  .inputOvervoltage(inputOvervoltage)
);

// >>> verif/pefr_host_model.sv
`timescale 1ns/10ps
// ==========
// Host side of the register read port
module pefr_host_model (
  input wire logic                 clk,
  input wire logic                 reqGo,
  input wire pefr_pkg::pefr_addr_t reqAddr,
  output logic                     regRead,
  output pefr_pkg::pefr_addr_t     regAddr
);
  import pefr_pkg::*;
  pefr_addr_t lastAddr = 8'h00;
  // Idle address keeps changing so a stale address never looks valid
  assign regRead = reqGo;
  assign regAddr = reqGo ? reqAddr : ~lastAddr;
  always_ff @(posedge clk) begin
    lastAddr <= regAddr;
  end
endmodule : pefr_host_model

// >>> verif/pefr_event_flags_tb.sv
`timescale 1ns/10ps
// ==========
// Self-checking bench for the event flag registers
module pefr_event_flags_tb;
  import pefr_pkg::*;
  logic clk, rst, reqGo, regRead, regRvalid, measValid, adcDone;
  logic thermalRegulationActive, safetyTimerExpired, wakeTimerAMet;
  logic wakeTimerBMet, adcOneShotMode, sequenceGood, inputGood;
  logic stepdownGood, updownGood, regulatorAGood, regulatorBGood;
  logic inputOvervoltage, thresholdADirection, thresholdBDirection;
  logic thresholdCDirection;
  pefr_addr_t reqAddr, regAddr, unm;
  pefr_data_t regRdata, eventFlagsOne, eventFlagsTwo;
  pefr_meas_t thresholdAMeas, thresholdBMeas, thresholdCMeas;
  pefr_meas_t thresholdALimit, thresholdBLimit, thresholdCLimit;
  pefr_chg_t  chargeStatus;
  pefr_data_t expQ[$];
  int         n_fail, checked, cycles, seed;

  pefr_event_flags dut (.*);
  pefr_host_model  host (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Note the answer first, the monitor pops it when regRvalid shows
  task automatic rd(input pefr_addr_t a, input pefr_data_t e);
    expQ.push_back(e);
    @(posedge clk);
    reqGo <= 1'b1;
    reqAddr <= a;
    @(posedge clk);
    reqGo <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Quiet levels: no events, rails good, samples off threshold
  task automatic idle;
    thermalRegulationActive <= 1'b0;
    safetyTimerExpired <= 1'b0;
    wakeTimerAMet <= 1'b0;
    wakeTimerBMet <= 1'b0;
    adcDone <= 1'b0;
    inputOvervoltage <= 1'b0;
    stepdownGood <= 1'b1;
    updownGood <= 1'b1;
    regulatorAGood <= 1'b1;
    regulatorBGood <= 1'b1;
    thresholdAMeas <= 12'h000;
    thresholdBMeas <= 12'h000;
    thresholdCMeas <= 12'hfff;
  endtask : idle

  // Index 15..8 is the first register bit 7..0, 7..0 the second
  task automatic hit(input int i);
    @(posedge clk);
    case (i)
      15: thermalRegulationActive <= 1'b1;
      14: safetyTimerExpired <= 1'b1;
      13: wakeTimerAMet <= 1'b1;
      12: wakeTimerBMet <= 1'b1;
      11: adcDone <= 1'b1;
      10: thresholdAMeas <= thresholdALimit + 12'h001;
      9: thresholdBMeas <= thresholdBLimit + 12'h001;
      8: thresholdCMeas <= 12'h000;
      7: chargeStatus <= chargeStatus + 2'h1;
      6: sequenceGood <= ~sequenceGood;
      5: stepdownGood <= 1'b0;
      4: updownGood <= 1'b0;
      3: regulatorAGood <= 1'b0;
      2: regulatorBGood <= 1'b0;
      1: inputGood <= ~inputGood;
      default: inputOvervoltage <= 1'b1;
    endcase
    measValid <= 1'b1;
    @(posedge clk);
    idle;
    @(posedge clk);
    measValid <= 1'b0;
  endtask : hit

  task automatic run_hit(input int i, input logic on);
    logic [15:0] ex;
    ex = on ? 16'h0001 << i : 16'h0000;
    hit(i);
    #1;
    chk("f1", eventFlagsOne, ex[15:8]);
    chk("f2", eventFlagsTwo, ex[7:0]);
    rd(i > 7 ? FLAGS_ONE_ADDR : FLAGS_TWO_ADDR, i > 7 ? ex[15:8] : ex[7:0]);
    rd(i > 7 ? FLAGS_ONE_ADDR : FLAGS_TWO_ADDR, 8'h00);
  endtask : run_hit

  // Read monitor and hang guard
  always @(posedge clk) begin
    cycles++;
    if (regRvalid === 1'b1) begin
      if (expQ.size() > 0)
        chk("rdata", regRdata, expQ.pop_front());
      else
        chk("extra", 16'h0001, 16'h0000);
    end
    if (cycles == 3000) begin
      n_fail++;
      wrap_up;
    end
  end

  initial begin
    seed = 297;
    rst = 1'b1;
    reqGo = 1'b0;
    reqAddr = 8'h00;
    measValid = 1'b0;
    adcOneShotMode = 1'b1;
    chargeStatus = 2'h0;
    sequenceGood = 1'b1;
    inputGood = 1'b1;
    thresholdADirection = 1'b1;
    thresholdBDirection = 1'b1;
    thresholdCDirection = 1'b0;
    // Limits kept in 1..7ff so both crossings stay reachable
    thresholdALimit = 12'($random(seed)) & 12'h7ff | 12'h001;
    thresholdBLimit = 12'($random(seed)) & 12'h7ff | 12'h001;
    thresholdCLimit = 12'($random(seed)) & 12'h7ff | 12'h001;
    unm = 8'h07 + 8'($random(seed) & 32'hf7);
    idle;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst", {eventFlagsOne, eventFlagsTwo}, 16'h0000);
    rd(FLAGS_ONE_ADDR, FLAGS_RESET);
    rd(FLAGS_TWO_ADDR, FLAGS_RESET);
    rd(unm, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
      run_hit(i, 1'b1);
    $display("test events done");
    adcOneShotMode <= 1'b0;
    run_hit(11, 1'b0);
    adcOneShotMode <= 1'b1;
    $display("test one-shot gate done");
    // Event on the edge of a clearing read must survive it
    expQ.push_back(8'h00);
    @(posedge clk);
    thermalRegulationActive <= 1'b1;
    reqGo <= 1'b1;
    reqAddr <= FLAGS_ONE_ADDR;
    @(posedge clk);
    thermalRegulationActive <= 1'b0;
    reqGo <= 1'b0;
    rd(FLAGS_ONE_ADDR, 8'h80);
    $display("test set wins done");
    hit(0);
    rd(unm, 8'h00);
    rd(FLAGS_TWO_ADDR, 8'h01);
    $display("test unmapped done");
    // Mid-run reset drops a set flag; detectors relearn before firing,
    // so the charge state left at a nonzero code raises nothing
    hit(15);
    #1;
    chk("pre", eventFlagsOne, 8'h80);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("mid", {eventFlagsOne, eventFlagsTwo}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    rd(FLAGS_ONE_ADDR, FLAGS_RESET);
    rd(FLAGS_TWO_ADDR, FLAGS_RESET);
    $display("test mid reset done");
    @(posedge clk);
    chk("left", 16'(expQ.size()), 16'h0000);
    wrap_up;
  end
endmodule : pefr_event_flags_tb
